//--- rtl/rlt_avg.sv
`timescale 1ns/1ps
`default_nettype none
module rlt_avg
    import rlt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // sample side
    input  wire logic [7:0] sample,
    input  wire logic       sample_vld,
    input  wire logic       avg_en,
    input  wire logic       restart,
    // level side
    output logic [7:0]      level_ff,
    output logic            level_vld_ff
);

    logic [9:0] sum_ff;
    logic [1:0] cnt_ff;
    logic [9:0] nxt_sum;

    assign nxt_sum = sum_ff + {2'h0, sample};

    // per-bit pass-through or mean of four consecutive samples
    always_ff @(posedge clk) begin
        if (srst || restart) begin
            sum_ff       <= 10'h000;
            cnt_ff       <= 2'h0;
            level_ff     <= 8'h00;
            level_vld_ff <= 1'b0;
        end else begin
            level_vld_ff <= 1'b0;
            if (sample_vld) begin
                if (!avg_en) begin
                    level_ff     <= sample;
                    level_vld_ff <= 1'b1;
                end else if (cnt_ff == 2'(RLT_AVG_LEN - 1)) begin
                    level_ff     <= nxt_sum[9:2]; // truncating mean
                    level_vld_ff <= 1'b1;
                    sum_ff       <= 10'h000;
                    cnt_ff       <= 2'h0;
                end else begin
                    sum_ff <= nxt_sum;
                    cnt_ff <= cnt_ff + 2'h1;
                end
            end
        end
    end

endmodule : rlt_avg
`default_nettype wire

//--- rtl/rlt_jump.sv
`timescale 1ns/1ps
`default_nettype none
module rlt_jump
    import rlt_pkg::*;
#(
    parameter int DEPTH = 8
)(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      srst,
    input  wire logic      restart,
    // level stream
    input  wire logic [7:0] level,
    input  wire logic       level_vld,
    input  wire rlt_jcfg_t  cfg,
    // event
    output logic            jump_ff
);

    logic [7:0] hist_ff [DEPTH];
    logic [2:0] fill_ff;
    logic [7:0] old_lvl;
    logic [2:0] ivl;
    logic       up_hit;
    logic       dn_hit;

    // interval zero is treated as one sample back
    assign ivl     = (cfg.interval == 3'h0) ? 3'h1 : cfg.interval;
    assign old_lvl = hist_ff[ivl - 3'h1];
    assign up_hit  = cfg.up_en && (level > old_lvl) && ((level - old_lvl) >= cfg.step);
    assign dn_hit  = cfg.dn_en && (old_lvl > level) && ((old_lvl - level) >= cfg.step);

    // history of levels, slope compare across the interval
    always_ff @(posedge clk) begin
        if (srst || restart) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist_ff[i] <= 8'h00;
            end
            fill_ff <= 3'h0;
            jump_ff <= 1'b0;
        end else begin
            jump_ff <= 1'b0;
            if (level_vld) begin
                hist_ff[0] <= level;
                for (int i = 1; i < DEPTH; i++) begin
                    hist_ff[i] <= hist_ff[i-1];
                end
                if (fill_ff != 3'h7) begin
                    fill_ff <= fill_ff + 3'h1;
                end
                // no compare until the history reaches the interval
                jump_ff <= (fill_ff >= ivl) && (up_hit || dn_hit);
            end
        end
    end

endmodule : rlt_jump
`default_nettype wire

//--- rtl/rlt_pkg.sv
package rlt_pkg;

    // bus decode
    localparam int          RLT_ADDR_W       = 8;
    localparam logic [7:0]  RLT_OFS_SETUP    = 8'h00;
    localparam logic [7:0]  RLT_OFS_OFFSET   = 8'h04;
    localparam logic [7:0]  RLT_OFS_LIMIT    = 8'h08;
    localparam logic [7:0]  RLT_OFS_STEP     = 8'h0C;
    localparam logic [7:0]  RLT_OFS_STATUS   = 8'h10;
    localparam logic [7:0]  RLT_OFS_SLOTSEL  = 8'h14;
    localparam logic [7:0]  RLT_OFS_SLOTS    = 8'h18;
    localparam logic [7:0]  RLT_OFS_QUERY    = 8'h1C;
    localparam logic [7:0]  RLT_OFS_QDATA    = 8'h20;

    // field positions
    localparam int RLT_SETUP_AVG_BIT   = 0;
    localparam int RLT_SETUP_TRIG_LSB  = 1;
    localparam int RLT_SETUP_CNT_LSB   = 8;
    localparam int RLT_STEP_UP_BIT     = 8;
    localparam int RLT_STEP_DN_BIT     = 9;
    localparam int RLT_STEP_RST_BIT    = 10;
    localparam int RLT_STEP_IVL_LSB    = 12;
    localparam int RLT_STAT_ABOVE_STK  = 17;
    localparam int RLT_STAT_JUMP_STK   = 18;

    // values after reset
    localparam logic [7:0]  RLT_RST_OFFSET   = 8'h40;
    localparam logic [7:0]  RLT_RST_LIMIT    = 8'hFF;
    localparam logic [7:0]  RLT_RST_STEP     = 8'h10;
    localparam logic [7:0]  RLT_RST_LCNT     = 8'h04;
    localparam logic [2:0]  RLT_RST_IVL      = 3'h4;

    // bit-period counts
    localparam logic [7:0]  RLT_MIN_BITS     = 8'h04;
    localparam logic [7:0]  RLT_MIN_BITS_AVG = 8'h07;
    localparam int          RLT_AVG_LEN      = 4;

    // query turnaround, longest time rounds down
    localparam int RLT_CLK_MHZ        = 125;
    localparam int RLT_QUERY_TIME_NS  = 33000;
    localparam int RLT_QUERY_CYCLES   = (RLT_QUERY_TIME_NS * RLT_CLK_MHZ) / 1000;

    // latch trigger select
    typedef enum logic [1:0] {
        RLT_TRIG_PREAMBLE = 2'h0,
        RLT_TRIG_SYNC     = 2'h1,
        RLT_TRIG_BITCNT   = 2'h2,
        RLT_TRIG_BITCNT2  = 2'h3
    } rlt_trig_t;

    // fast slot content select
    typedef enum logic [1:0] {
        RLT_SLOT_NONE    = 2'h0,
        RLT_SLOT_LATCHED = 2'h1,
        RLT_SLOT_CURRENT = 2'h2,
        RLT_SLOT_FLAGS   = 2'h3
    } rlt_slot_t;

    // query engine states
    typedef enum logic [2:0] {
        RLT_Q_IDLE  = 3'b001,
        RLT_Q_WAIT  = 3'b010,
        RLT_Q_READY = 3'b100
    } rlt_qstate_t;

    // captured ahb address phase
    typedef struct packed {
        logic                   wr;
        logic [RLT_ADDR_W-1:0]  addr;
    } rlt_aphase_t;

    // jump detector setup
    typedef struct packed {
        logic       up_en;
        logic       dn_en;
        logic       restart_en;
        logic [2:0] interval;
        logic [7:0] step;
    } rlt_jcfg_t;

endpackage : rlt_pkg

//--- rtl/rlt_top.sv
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rlt_top
    import rlt_pkg::*;
#(
    parameter int QUERY_CYCLES = RLT_QUERY_CYCLES
)(
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  SRST,
    // ahb-lite slave
    input  wire logic                  HSEL,
    input  wire logic [RLT_ADDR_W-1:0] HADDR,
    input  wire logic [1:0]            HTRANS,
    input  wire logic                  HWRITE,
    input  wire logic [2:0]            HSIZE,
    input  wire logic [31:0]           HWDATA,
    input  wire logic                  HREADY,
    output logic [31:0]                HRDATA,
    output logic                       HREADYOUT,
    output logic                       HRESP,
    // modem side, same clock domain
    input  wire logic [7:0]            RX_LEVEL,
    input  wire logic                  RX_LEVEL_VLD,
    input  wire logic                  RX_ENTER,
    input  wire logic                  PREAMBLE_DET,
    input  wire logic                  SYNC_DET,
    // notification pins
    output logic                       ABOVE_LIVE,
    output logic                       ABOVE_HELD,
    output logic                       JUMP_PIN,
    output logic                       RX_RESTART
);

    // configuration registers
    logic        avg_en_ff;
    rlt_trig_t   trig_ff;
    logic [7:0]  lcnt_ff;
    logic [7:0]  offset_ff;
    logic [7:0]  limit_ff;
    rlt_jcfg_t   jcfg_ff;
    logic [7:0]  slotsel_ff;

    // measurement state
    logic [7:0]  cur_level;
    logic        cur_vld;
    logic [7:0]  latched_ff;
    logic        latch_done_ff;
    logic [7:0]  bitcnt_ff;
    logic        above_live_ff;
    logic        above_stk_ff;
    logic        jump_stk_ff;
    logic        jump_evt;
    logic        restart_ff;

    // query engine
    rlt_qstate_t q_state_ff;
    logic [12:0] q_cnt_ff;
    logic [7:0]  q_cur_ff;
    logic [7:0]  q_lat_ff;

    // bus
    rlt_aphase_t ap_ff;
    logic        ap_vld_ff;
    logic        ap_take;
    logic        wr_now;
    logic [31:0] nxt_rdata;
    logic        clr_above;
    logic        clr_jump;
    logic        q_start;
    logic        latch_fire;
    logic [7:0]  min_bits;

    // restart of acquisition, either by the modem or by a jump
    logic        rx_start;
    assign rx_start = RX_ENTER || restart_ff;

    // level source: samples come from the channel filter output
    rlt_avg u_avg (
        .clk          (CLK),
        .srst         (SRST),
        .sample       (RX_LEVEL),
        .sample_vld   (RX_LEVEL_VLD),
        .avg_en       (avg_en_ff),
        .restart      (rx_start),
        .level_ff     (cur_level),
        .level_vld_ff (cur_vld)
    );

    // slope-based jump detector
    rlt_jump #(
        .DEPTH (8)
    ) u_jump (
        .clk       (CLK),
        .srst      (SRST),
        .restart   (rx_start),
        .level     (cur_level),
        .level_vld (cur_vld),
        .cfg       (jcfg_ff),
        .jump_ff   (jump_evt)
    );

    // bit periods since receive start, saturating
    always_ff @(posedge CLK) begin
        if (SRST || rx_start) begin
            bitcnt_ff <= 8'h00;
        end else if (RX_LEVEL_VLD && bitcnt_ff != 8'hFF) begin
            bitcnt_ff <= bitcnt_ff + 8'h01;
        end
    end

    // earliest latch point; the filter needs four bits, the average seven
    function automatic logic [7:0] rlt_max8(input logic [7:0] a, input logic [7:0] b);
        rlt_max8 = (a > b) ? a : b;
    endfunction : rlt_max8

    assign min_bits = avg_en_ff ? rlt_max8(lcnt_ff, RLT_MIN_BITS_AVG)
                                : rlt_max8(lcnt_ff, RLT_MIN_BITS);

    // trigger select; with averaging on, every trigger is also held off until seven bits
    always_comb begin
        latch_fire = 1'b0;
        unique case (trig_ff)
            RLT_TRIG_PREAMBLE: latch_fire = PREAMBLE_DET;
            RLT_TRIG_SYNC:     latch_fire = SYNC_DET;
            RLT_TRIG_BITCNT,
            RLT_TRIG_BITCNT2:  latch_fire = (bitcnt_ff >= min_bits);
        endcase
        if (avg_en_ff && bitcnt_ff < RLT_MIN_BITS_AVG) begin
            latch_fire = 1'b0;
        end
    end

    // once-per-packet latch, cleared on receive entry
    always_ff @(posedge CLK) begin
        if (SRST || rx_start) begin
            latched_ff    <= 8'h00;
            latch_done_ff <= 1'b0;
        end else if (latch_fire && !latch_done_ff) begin
            latched_ff    <= cur_level;
            latch_done_ff <= 1'b1;
        end
    end

    // live threshold compare against the current level
    always_ff @(posedge CLK) begin
        if (SRST) begin
            above_live_ff <= 1'b0;
        end else begin
            above_live_ff <= (cur_level > limit_ff);
        end
    end

    // sticky above flag; a new event wins over a software clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            above_stk_ff <= 1'b0;
        end else if (above_live_ff) begin
            above_stk_ff <= 1'b1;
        end else if (clr_above) begin
            above_stk_ff <= 1'b0;
        end
    end

    // sticky jump flag, same set-over-clear priority
    always_ff @(posedge CLK) begin
        if (SRST) begin
            jump_stk_ff <= 1'b0;
        end else if (jump_evt) begin
            jump_stk_ff <= 1'b1;
        end else if (clr_jump) begin
            jump_stk_ff <= 1'b0;
        end
    end

    // jump-driven restart pulse, one cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= jump_evt && jcfg_ff.restart_en;
        end
    end

    // pins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ABOVE_LIVE <= 1'b0;
            ABOVE_HELD <= 1'b0;
            JUMP_PIN   <= 1'b0;
            RX_RESTART <= 1'b0;
        end else begin
            ABOVE_LIVE <= above_live_ff;
            ABOVE_HELD <= above_stk_ff;
            JUMP_PIN   <= jump_stk_ff;
            RX_RESTART <= restart_ff;
        end
    end

    // query engine: snapshot when taken, ready after the turnaround
    always_ff @(posedge CLK) begin
        if (SRST) begin
            q_state_ff <= RLT_Q_IDLE;
            q_cnt_ff   <= 13'h0000;
            q_cur_ff   <= 8'h00;
            q_lat_ff   <= 8'h00;
        end else if (q_start) begin
            q_state_ff <= RLT_Q_WAIT;
            q_cnt_ff   <= 13'h0000;
            q_cur_ff   <= cur_level;
            q_lat_ff   <= latched_ff;
        end else begin
            unique case (q_state_ff)
                RLT_Q_IDLE: begin
                    q_cnt_ff <= 13'h0000;
                end
                RLT_Q_WAIT: begin
                    if (q_cnt_ff == 13'(QUERY_CYCLES - 1)) begin
                        q_state_ff <= RLT_Q_READY;
                    end else begin
                        q_cnt_ff <= q_cnt_ff + 13'h0001;
                    end
                end
                RLT_Q_READY: begin
                    q_cnt_ff <= 13'h0000;
                end
                default: begin
                    q_state_ff <= RLT_Q_IDLE;
                end
            endcase
        end
    end

    // fast slot byte, readable with no wait on the query
    function automatic logic [7:0] rlt_slot(input logic [1:0] sel);
        unique case (rlt_slot_t'(sel))
            RLT_SLOT_NONE:    rlt_slot = 8'h00;
            RLT_SLOT_LATCHED: rlt_slot = latched_ff;
            RLT_SLOT_CURRENT: rlt_slot = cur_level;
            RLT_SLOT_FLAGS:   rlt_slot = {4'h0, latch_done_ff, jump_stk_ff, above_stk_ff, above_live_ff};
        endcase
    endfunction : rlt_slot

    // ahb address phase acceptance; zero wait, always ready
    assign ap_take = HSEL && HREADY && HTRANS[1];
    assign wr_now  = ap_vld_ff && ap_ff.wr;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ap_vld_ff <= 1'b0;
            ap_ff     <= '0;
        end else begin
            ap_vld_ff <= ap_take;
            ap_ff     <= '{wr: HWRITE, addr: HADDR};
        end
    end

    // write side effects in the data phase
    assign clr_above = wr_now && (ap_ff.addr == RLT_OFS_STATUS) && HWDATA[RLT_STAT_ABOVE_STK];
    assign clr_jump  = wr_now && (ap_ff.addr == RLT_OFS_STATUS) && HWDATA[RLT_STAT_JUMP_STK];
    assign q_start   = wr_now && (ap_ff.addr == RLT_OFS_QUERY);

    // configuration writes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            avg_en_ff  <= 1'b0;
            trig_ff    <= RLT_TRIG_BITCNT;
            lcnt_ff    <= RLT_RST_LCNT;
            offset_ff  <= RLT_RST_OFFSET;
            limit_ff   <= RLT_RST_LIMIT;
            jcfg_ff    <= '{up_en: 1'b0, dn_en: 1'b0, restart_en: 1'b0,
                            interval: RLT_RST_IVL, step: RLT_RST_STEP};
            slotsel_ff <= 8'h55;
        end else if (wr_now) begin
            unique case (ap_ff.addr)
                RLT_OFS_SETUP: begin
                    avg_en_ff <= HWDATA[RLT_SETUP_AVG_BIT];
                    trig_ff   <= rlt_trig_t'(HWDATA[RLT_SETUP_TRIG_LSB +: 2]);
                    lcnt_ff   <= HWDATA[RLT_SETUP_CNT_LSB +: 8];
                end
                RLT_OFS_OFFSET: begin
                    offset_ff <= HWDATA[7:0];
                end
                RLT_OFS_LIMIT: begin
                    limit_ff <= HWDATA[7:0];
                end
                RLT_OFS_STEP: begin
                    jcfg_ff <= '{up_en:      HWDATA[RLT_STEP_UP_BIT],
                                 dn_en:      HWDATA[RLT_STEP_DN_BIT],
                                 restart_en: HWDATA[RLT_STEP_RST_BIT],
                                 interval:   HWDATA[RLT_STEP_IVL_LSB +: 3],
                                 step:       HWDATA[7:0]};
                end
                RLT_OFS_SLOTSEL: begin
                    slotsel_ff <= HWDATA[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // read mux, registered at the address phase
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (HADDR)
            RLT_OFS_SETUP:   nxt_rdata = {16'h0000, lcnt_ff, 5'h00, trig_ff, avg_en_ff};
            RLT_OFS_OFFSET:  nxt_rdata = {24'h000000, offset_ff};
            RLT_OFS_LIMIT:   nxt_rdata = {24'h000000, limit_ff};
            RLT_OFS_STEP:    nxt_rdata = {17'h00000, jcfg_ff.interval, 1'b0, jcfg_ff.restart_en,
                                          jcfg_ff.dn_en, jcfg_ff.up_en, jcfg_ff.step};
            RLT_OFS_STATUS:  nxt_rdata = {12'h000, latch_done_ff, jump_stk_ff, above_stk_ff,
                                          above_live_ff, latched_ff, cur_level};
            RLT_OFS_SLOTSEL: nxt_rdata = {24'h000000, slotsel_ff};
            RLT_OFS_SLOTS:   nxt_rdata = {rlt_slot(slotsel_ff[7:6]), rlt_slot(slotsel_ff[5:4]),
                                          rlt_slot(slotsel_ff[3:2]), rlt_slot(slotsel_ff[1:0])};
            RLT_OFS_QUERY:   nxt_rdata = {30'h00000000, (q_state_ff == RLT_Q_WAIT),
                                          (q_state_ff == RLT_Q_READY)};
            RLT_OFS_QDATA:   nxt_rdata = {16'h0000, q_lat_ff, q_cur_ff};
            default:         nxt_rdata = 32'h0000_0000;
        endcase
    end

    // bus outputs; unmapped reads give zero with an okay answer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b0;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            if (ap_take && !HWRITE) begin
                HRDATA <= nxt_rdata;
            end
        end
    end

endmodule : rlt_top
`default_nettype wire

//--- verif/rlt_ahb_host.sv
`timescale 1ns/1ps
`default_nettype none
module rlt_ahb_host
    import rlt_pkg::*;
(
    // clock
    input  wire logic                 CLK,
    // master outputs
    output var logic                  HSEL,
    output var logic [RLT_ADDR_W-1:0] HADDR,
    output var logic [1:0]            HTRANS,
    output var logic                  HWRITE,
    output var logic [31:0]           HWDATA,
    // slave answer
    input  wire logic                 HREADY,
    input  wire logic [31:0]          HRDATA
);
    // idle bus from time zero
    initial begin
        {HSEL, HADDR, HTRANS, HWRITE, HWDATA} = '0;
    end
    // hold the phase until ready is seen; bounded so a stuck slave ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge CLK);
        while (HREADY !== 1'b1) begin
            n++;
            if (n > 64) begin
                rlt_top_tb.mismatches++;
                rlt_top_tb.wrap_up();
            end
            @(posedge CLK);
        end
    endtask : wait_rdy
    // one whole-word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HADDR  <= a;
        HWRITE <= w;
        wait_rdy();
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        q = HRDATA;
    endtask : xfer
endmodule : rlt_ahb_host
`default_nettype wire

//--- verif/rlt_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rlt_top_checker
    import rlt_pkg::*;
(
    // clock, reset, bus
    input wire logic                  CLK,
    input wire logic                  SRST,
    input wire logic                  HSEL,
    input wire logic [RLT_ADDR_W-1:0] HADDR,
    input wire logic [1:0]            HTRANS,
    input wire logic                  HWRITE,
    input wire logic                  HREADY,
    input wire logic [31:0]           HRDATA,
    input wire logic                  HREADYOUT,
    input wire logic                  HRESP,
    // notification pins
    input wire logic                  ABOVE_LIVE,
    input wire logic                  ABOVE_HELD,
    input wire logic                  JUMP_PIN,
    input wire logic                  RX_RESTART
);
    logic wr_stat_ff;
    logic rd_void_ff;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // address phases whose data phase comes next; only addresses above QDATA count as unmapped
    always_ff @(posedge CLK) begin
        wr_stat_ff <= HSEL & HREADY & HTRANS[1] & HWRITE & (HADDR == RLT_OFS_STATUS);
        rd_void_ff <= HSEL & HREADY & HTRANS[1] & !HWRITE & (HADDR > RLT_OFS_QDATA);
    end
    a_resp_okay: assert property (HRESP == 1'b0) else $error("bus response not okay");
    a_ready_nowait: assert property (!$past(SRST) |-> HREADYOUT) else $error("slave stalled");
    a_void_zero: assert property (rd_void_ff |-> HRDATA == 32'h0) else $error("unmapped read not zero");
    a_restart_once: assert property (RX_RESTART |=> !RX_RESTART) else $error("restart wider than one cycle");
    a_restart_jump: assert property (RX_RESTART |-> ##[0:1] JUMP_PIN) else $error("restart without jump");
    a_held_follow: assert property (ABOVE_LIVE |-> ##[0:2] ABOVE_HELD) else $error("above not held");
    // clear lands at the data-phase edge, the pin drops one edge later: fall is seen two edges after the flag
    a_held_sticky: assert property ($fell(ABOVE_HELD) |-> $past(wr_stat_ff, 2)) else $error("held dropped");
    a_jump_sticky: assert property ($fell(JUMP_PIN) |-> $past(wr_stat_ff, 2)) else $error("jump dropped");
    c_restart: cover property (RX_RESTART);
    c_held: cover property ($rose(ABOVE_HELD));
    c_void: cover property (rd_void_ff);
endmodule : rlt_top_checker
bind rlt_top rlt_top_checker u_chk (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .ABOVE_LIVE(ABOVE_LIVE), .ABOVE_HELD(ABOVE_HELD), .JUMP_PIN(JUMP_PIN), .RX_RESTART(RX_RESTART));
`default_nettype wire

//--- verif/rlt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rlt_top_tb;
    import rlt_pkg::*;
    logic        clk = 0, srst = 1, vld = 0, enter = 0, pre = 0, sync = 0;
    logic [7:0]  lvl = 0, haddr, lv, mv;
    logic [1:0]  htrans;
    logic        hsel, hwrite, hready, hresp, live, held, jmp, rst;
    logic [31:0] hwdata, hrdata, r;
    int          mismatches, n_checks, sum, q[$];
    logic [7:0]  ra[5] = '{RLT_OFS_SETUP, RLT_OFS_OFFSET, RLT_OFS_LIMIT, RLT_OFS_STEP, RLT_OFS_SLOTSEL};
    logic [31:0] rv[5] = '{32'h404, 32'h40, 32'hFF, 32'h4010, 32'h55};
    always #4 clk = ~clk;
    rlt_ahb_host h (.CLK(clk), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata));
    rlt_top #(.QUERY_CYCLES(20)) dut (.CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .RX_LEVEL(lvl), .RX_LEVEL_VLD(vld), .RX_ENTER(enter), .PREAMBLE_DET(pre),
        .SYNC_DET(sync), .ABOVE_LIVE(live), .ABOVE_HELD(held), .JUMP_PIN(jmp), .RX_RESTART(rst));
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // host side conversion of a code to dBm; any unknown bit of c[7:1] makes the whole result unknown, c[0] is dropped
    function automatic logic signed [9:0] dbm(input logic [7:0] c, input logic [7:0] o);
        dbm = $signed({3'b000, c[7:1]}) - $signed({2'b00, o}) - 10'sd70;
    endfunction : dbm
    task wr(input logic [7:0] a, input logic [31:0] d); h.xfer(1'b1, a, d, r); endtask : wr
    task rd(input logic [7:0] a); h.xfer(1'b0, a, 32'h0, r); endtask : rd
    // one level sample, then let measurement and compare settle
    task smp(input logic [7:0] v);
        lvl <= v;
        vld <= 1'b1;
        @(posedge clk) vld <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : smp
    task start_rx;
        enter <= 1'b1;
        @(posedge clk) enter <= 1'b0;
    endtask : start_rx
    // main sequence
    initial begin
        void'($urandom(24088));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i]);
            `CHK(r, rv[i])
        end
        rd(8'h24);
        `CHK(r, 32'h0)
        // latch on preamble, sync and bit count; count below minimum
        for (int t = 0; t < 3; t++) begin
            lv = 8'h40 + 8'($urandom_range(0, 63));
            mv = lv + 8'h20;
            wr(RLT_OFS_SETUP, 32'h200 | (t << 1));
            start_rx();
            repeat (2) smp(lv);
            rd(RLT_OFS_STATUS);
            `CHK(r[15:8], 8'h00)
            repeat (3) smp(lv);
            pre <= (t == 0);
            sync <= (t == 1);
            @(posedge clk) {pre, sync} <= 2'b00;
            repeat (3) smp(mv);
            rd(RLT_OFS_STATUS);
            `CHK(r[15:0], {lv, mv})
            rd(RLT_OFS_SLOTS);
            `CHK(r, {4{lv}})
            `CHK(dbm(r[7:0], RLT_RST_OFFSET), 10'(int'(lv) / 2 - 134))
        end
        // query: busy first, then ready with snapshot
        wr(RLT_OFS_QUERY, 32'h1);
        rd(RLT_OFS_QUERY);
        `CHK(r[1:0], 2'b10)
        for (int n = 0; n < 40 && r[0] !== 1'b1; n++) rd(RLT_OFS_QUERY);
        `CHK(r[0], 1'b1)
        rd(RLT_OFS_QDATA);
        `CHK(r[15:0], {lv, mv})
        // four-bit mean, latch held back to seven bits
        wr(RLT_OFS_SETUP, 32'h405);
        start_rx();
        for (int i = 0; i < 4; i++) begin
            q.push_back($urandom_range(0, 255));
            smp(8'(q[i]));
        end
        sum = q.sum();
        rd(RLT_OFS_STATUS);
        `CHK(r[15:0], {8'h00, 8'(sum >> 2)})
        repeat (2) smp(8'hF0);
        rd(RLT_OFS_STATUS);
        `CHK(r[15:8], 8'h00)
        // seventh bit: latch now takes the completed mean
        smp(8'hF0);
        rd(RLT_OFS_STATUS);
        `CHK(r[15:8], 8'(sum >> 2))
        // limit compare, live and held forms
        wr(RLT_OFS_SETUP, 32'h404);
        wr(RLT_OFS_LIMIT, 32'h80);
        smp(8'h81);
        `CHK(live, 1'b1)
        smp(8'h80);
        `CHK({live, held}, 2'b01)
        wr(RLT_OFS_STATUS, 32'h1 << RLT_STAT_ABOVE_STK);
        repeat (2) @(posedge clk);
        `CHK(held, 1'b0)
        // downward step: flagged only when the down direction is enabled
        for (int d = 0; d < 2; d++) begin
            start_rx();
            repeat (3) smp(8'h30);
            // interval four, step 0x30, restart on: a 0x20 drop stays quiet, 0x30 across four bits fires
            wr(RLT_OFS_STEP, 32'h4430 | (1 << (8 + d)));
            repeat (2) smp(8'h30);
            repeat (2) smp(8'h10);
            `CHK(jmp, 1'b0)
            repeat (2) smp(8'h00);
            `CHK(jmp, 1'(d))
            wr(RLT_OFS_STATUS, 32'h1 << RLT_STAT_JUMP_STK);
            repeat (2) @(posedge clk);
            `CHK(jmp, 1'b0)
        end
        wrap_up();
    end
endmodule : rlt_top_tb
`default_nettype wire
